// File: logic/sspc_ctrl.sv
// Serial programming interface and power/oscillator control of a synthesizer.
// Assumes serial clock, data, strobe and chip enable arrive asynchronously.
//
// Behaviour
// - Shift register is 32 bits: low 4 bits address, upper 28 bits data.
// - While strobe low, each serial clock rise shifts one bit in, MSB first.
// - Strobe rising edge copies the data field into the addressed register.
// - While strobe stays high, serial clock pulses shift nothing.
// - Powerdown is set by the powerdown field or the chip enable pin.
// - Partial powerdown stops oscillator, loop, buffers; regulators stay on.
// - Full powerdown stops oscillator, loop, buffers and regulators.
// - External source mode takes feedback from the external input.
// - Full synthesizer mode enables the internal oscillator.
// - Software reset restores defaults within 1 us and clears itself.
// - Register 0 write with skip bit 0 calibrates; fastlock when count > 0.
`default_nettype none
module sspc_ctrl #(
	parameter int NUM_REGS = sspc_pkg::NUM_REGS
) (
	input wire logic CORE_CLK,
	input wire logic RST_N,
	input wire logic SER_CLK,
	input wire logic SER_DATA,
	input wire logic LOAD_STROBE,
	input wire logic CHIP_ENABLE,
	input wire logic [3:0] REG_INDEX,
	output logic [27:0] REG_VALUE,
	output logic WRITE_PULSE,
	output logic [3:0] WRITE_ADDR,
	output logic CAL_START,
	output logic FASTLOCK_START,
	output logic OSC_ENABLE,
	output logic LOOP_ENABLE,
	output logic BUFFER_ENABLE,
	output logic REGULATOR_ENABLE,
	output logic FEEDBACK_EXTERNAL,
	output logic DETECTOR_POLARITY
);
	if (NUM_REGS != 16) begin : g_bad_num_regs
		$error("Address field decodes exactly sixteen registers");
	end
	if (sspc_pkg::SWRESET_CYC > sspc_pkg::SWRESET_MAX_CYC) begin : g_bad_reset
		$error("Software reset slower than its deadline");
	end

	////////////////////////////////////////////////////////////////////////
	// Input synchronisation and edge detection
	logic [3:0] pins_s;
	logic sclk_s, sdata_s, strobe_s, ce_s;
	logic sclk_prev_q, strobe_prev_q;

	sspc_sync #(
		.WIDTH(sspc_pkg::SYNC_W),
		.RESET_VALUE(sspc_pkg::SYNC_RESET)
	) u_sync (
		.clk(CORE_CLK),
		.rst_n(RST_N),
		.async_in({SER_CLK, SER_DATA, LOAD_STROBE, CHIP_ENABLE}),
		.sync_out(pins_s)
	);
	assign {sclk_s, sdata_s, strobe_s, ce_s} = pins_s;

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			sclk_prev_q <= 1'b0;
			strobe_prev_q <= 1'b1;
		end else begin
			sclk_prev_q <= sclk_s;
			strobe_prev_q <= strobe_s;
		end
	end

	logic sclk_rise, strobe_rise;
	assign sclk_rise = sclk_s && !sclk_prev_q && !strobe_s;
	assign strobe_rise = strobe_s && !strobe_prev_q;

	////////////////////////////////////////////////////////////////////////
	// Shift register
	logic [31:0] shift_q, shift_d;

	always_comb begin
		shift_d = shift_q;
		if (sclk_rise)
			shift_d = {shift_q[30:0], sdata_s};
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N)
			shift_q <= 32'h0000_0000;
		else
			shift_q <= shift_d;
	end

	logic [3:0] addr_f;
	logic [27:0] data_f;
	assign addr_f = shift_q[3:0];
	assign data_f = shift_q[31:4];

	logic sw_reset;
	assign sw_reset = strobe_rise && addr_f == sspc_pkg::REG_CONTROL &&
		data_f[sspc_pkg::SWRESET_POS];

	////////////////////////////////////////////////////////////////////////
	// Register bank, one entry per address
	logic [27:0] regs_q [NUM_REGS];
	logic [27:0] regs_d [NUM_REGS];

	for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
		always_comb begin
			regs_d[i] = regs_q[i];
			if (sw_reset)
				regs_d[i] = sspc_pkg::REG_DEFAULT;
			else if (strobe_rise && addr_f == 4'(i))
				regs_d[i] = data_f;
		end

		always_ff @(posedge CORE_CLK or negedge RST_N) begin
			if (!RST_N)
				regs_q[i] <= sspc_pkg::REG_DEFAULT;
			else
				regs_q[i] <= regs_d[i];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Write events
	logic [11:0] fl_count;
	assign fl_count = regs_q[sspc_pkg::REG_FASTLOCK]
		[sspc_pkg::FL_COUNT_LSB +: sspc_pkg::FL_COUNT_W];

	logic main_write;
	assign main_write = strobe_rise && addr_f == sspc_pkg::REG_MAIN;

	logic wr_pulse_q, wr_pulse_d, cal_q, cal_d, fl_q, fl_d;
	logic [3:0] wr_addr_q, wr_addr_d;
	logic [27:0] value_q, value_d;

	always_comb begin
		wr_pulse_d = strobe_rise;
		wr_addr_d = strobe_rise ? addr_f : wr_addr_q;
		cal_d = main_write && !data_f[sspc_pkg::SKIP_CAL_POS];
		fl_d = main_write && fl_count != 12'h000;
		value_d = regs_q[REG_INDEX];
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			wr_pulse_q <= 1'b0;
			wr_addr_q <= 4'h0;
			cal_q <= 1'b0;
			fl_q <= 1'b0;
			value_q <= 28'h000_0000;
		end else begin
			wr_pulse_q <= wr_pulse_d;
			wr_addr_q <= wr_addr_d;
			cal_q <= cal_d;
			fl_q <= fl_d;
			value_q <= value_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Powerdown and oscillator source
	sspc_pkg::sspc_pd_t pd_sel;
	logic ext_osc;
	assign pd_sel = sspc_pkg::sspc_pd_t'(regs_q[sspc_pkg::REG_CONTROL]
		[sspc_pkg::PD_SELECT_LSB +: 2]);
	assign ext_osc = regs_q[sspc_pkg::REG_CONTROL][sspc_pkg::EXT_OSC_POS];

	logic pd_partial, pd_full;
	always_comb begin
		pd_partial = 1'b0;
		pd_full = 1'b0;
		unique case (pd_sel)
			sspc_pkg::SSPC_PD_PIN_FULL: pd_full = !ce_s;
			sspc_pkg::SSPC_PD_PARTIAL: pd_partial = 1'b1;
			sspc_pkg::SSPC_PD_FULL: pd_full = 1'b1;
			sspc_pkg::SSPC_PD_PIN_PARTIAL: pd_partial = !ce_s;
		endcase
	end

	logic osc_q, osc_d, loop_q, loop_d, buf_q, buf_d, ldo_q, ldo_d;
	logic fbx_q, fbx_d, pol_q, pol_d;

	always_comb begin
		loop_d = !(pd_partial || pd_full);
		buf_d = !(pd_partial || pd_full);
		osc_d = !(pd_partial || pd_full) && !ext_osc;
		ldo_d = !pd_full;
		fbx_d = ext_osc;
		pol_d = regs_q[sspc_pkg::REG_GAIN][sspc_pkg::POLARITY_POS];
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			osc_q <= 1'b0;
			loop_q <= 1'b0;
			buf_q <= 1'b0;
			ldo_q <= 1'b0;
			fbx_q <= 1'b0;
			pol_q <= 1'b0;
		end else begin
			osc_q <= osc_d;
			loop_q <= loop_d;
			buf_q <= buf_d;
			ldo_q <= ldo_d;
			fbx_q <= fbx_d;
			pol_q <= pol_d;
		end
	end

	assign REG_VALUE = value_q;
	assign WRITE_PULSE = wr_pulse_q;
	assign WRITE_ADDR = wr_addr_q;
	assign CAL_START = cal_q;
	assign FASTLOCK_START = fl_q;
	assign OSC_ENABLE = osc_q;
	assign LOOP_ENABLE = loop_q;
	assign BUFFER_ENABLE = buf_q;
	assign REGULATOR_ENABLE = ldo_q;
	assign FEEDBACK_EXTERNAL = fbx_q;
	assign DETECTOR_POLARITY = pol_q;
endmodule : sspc_ctrl
`default_nettype wire

// File: logic/sspc_sync.sv
// Two-flop synchroniser for a group of independent levels.
// Assumes each bit is a slow level compared with the core clock.
`default_nettype none
module sspc_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= RESET_VALUE;
			sync_q <= RESET_VALUE;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;
endmodule : sspc_sync
`default_nettype wire

// File: shared/sspc_pkg.sv
// Constants shared by the synthesizer serial programming control block.
// Assumes a single core clock and a host that drives clock, data and strobe.
`default_nettype none
package sspc_pkg;
	localparam int SHIFT_W = 32;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 28;
	localparam int NUM_REGS = 16;
	localparam int SYNC_W = 4;
	// Synchroniser state after reset, bits {clock, data, strobe, enable}.
	// The strobe starts high so that its idle level gives no false rise.
	localparam logic [3:0] SYNC_RESET = 4'h2;

	// Core clock and the software reset deadline
	localparam int CORE_CLK_HZ = 25_000_000;
	localparam int CORE_PERIOD_NS = 1_000_000_000 / CORE_CLK_HZ;
	localparam int SWRESET_MAX_NS = 1_000;
	localparam int SWRESET_MAX_CYC = (SWRESET_MAX_NS / CORE_PERIOD_NS < 1) ?
		1 : SWRESET_MAX_NS / CORE_PERIOD_NS;
	localparam int SWRESET_CYC = 1;

	// Register indices
	localparam logic [3:0] REG_MAIN = 4'h0;
	localparam logic [3:0] REG_GAIN = 4'h1;
	localparam logic [3:0] REG_FASTLOCK = 4'h4;
	localparam logic [3:0] REG_CONTROL = 4'h5;

	// Field positions inside the 28-bit data field
	localparam int SKIP_CAL_POS = 0;
	localparam int SWRESET_POS = 0;
	localparam int PD_SELECT_LSB = 1;
	localparam int EXT_OSC_POS = 3;
	localparam int POLARITY_POS = 0;
	localparam int FL_COUNT_LSB = 0;
	localparam int FL_COUNT_W = 12;

	// Power-on default of every register
	localparam logic [27:0] REG_DEFAULT = 28'h000_0000;

	// Powerdown select encoding
	typedef enum logic [1:0] {
		SSPC_PD_PIN_FULL = 2'b00,
		SSPC_PD_PARTIAL = 2'b01,
		SSPC_PD_FULL = 2'b10,
		SSPC_PD_PIN_PARTIAL = 2'b11
	} sspc_pd_t;
endpackage : sspc_pkg
`default_nettype wire

// File: testbench/sspc_ctrl_chk.sv
// Port assertions of the serial programming control.
// Assumes it is bound into sspc_ctrl.
`default_nettype none
module sspc_ctrl_chk (
	input wire logic CORE_CLK,
	input wire logic RST_N,
	input wire logic LOAD_STROBE,
	input wire logic WRITE_PULSE,
	input wire logic [3:0] WRITE_ADDR,
	input wire logic CAL_START,
	input wire logic FASTLOCK_START,
	input wire logic OSC_ENABLE,
	input wire logic LOOP_ENABLE,
	input wire logic BUFFER_ENABLE,
	input wire logic REGULATOR_ENABLE,
	input wire logic FEEDBACK_EXTERNAL
);
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RST_N);
	property p_pulse;
		WRITE_PULSE |=> !WRITE_PULSE;
	endproperty
	a_pulse: assert property (p_pulse) else $error("pulse");
	property p_latch;
		WRITE_PULSE |-> $past(LOAD_STROBE) && !$past(LOAD_STROBE, 6);
	endproperty
	a_latch: assert property (p_latch) else $error("latch");
	property p_addr;
		$changed(WRITE_ADDR) |-> WRITE_PULSE;
	endproperty
	a_addr: assert property (p_addr) else $error("addr");
	property p_cal;
		CAL_START |-> WRITE_PULSE && WRITE_ADDR == 4'h0;
	endproperty
	a_cal: assert property (p_cal) else $error("cal");
	property p_fl;
		FASTLOCK_START |-> WRITE_PULSE && WRITE_ADDR == 4'h0;
	endproperty
	a_fl: assert property (p_fl) else $error("fastlock");
	property p_full;
		!REGULATOR_ENABLE |-> !(OSC_ENABLE || LOOP_ENABLE || BUFFER_ENABLE);
	endproperty
	a_full: assert property (p_full) else $error("full pd");
	property p_part;
		(LOOP_ENABLE == BUFFER_ENABLE) && (LOOP_ENABLE || !OSC_ENABLE);
	endproperty
	a_part: assert property (p_part) else $error("partial pd");
	property p_ext;
		$rose(FEEDBACK_EXTERNAL) |-> ##[0:1] !OSC_ENABLE;
	endproperty
	a_ext: assert property (p_ext) else $error("ext");
endmodule : sspc_ctrl_chk
bind sspc_ctrl sspc_ctrl_chk i_sspc_ctrl_chk (.CORE_CLK, .RST_N,
	.LOAD_STROBE, .WRITE_PULSE, .WRITE_ADDR, .CAL_START, .FASTLOCK_START,
	.OSC_ENABLE, .LOOP_ENABLE, .BUFFER_ENABLE, .REGULATOR_ENABLE,
	.FEEDBACK_EXTERNAL);
`default_nettype wire

// File: testbench/sspc_ctrl_tb.sv
// Bench of the serial programming control.
// Assumes the host model and the checker are compiled first.
`default_nettype none
module sspc_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_n, ce, sck, sd, ld, wp, cal, fl, pol;
	logic [3:0] idx, wa;
	logic [27:0] rv;
	wire logic [4:0] en;
	int err_total = 0;
	int total_checks = 0;
	int cal_n = 0;
	int fl_n = 0;
	logic [3:0] order [13] = '{4'hf, 4'hd, 4'ha, 4'h9, 4'h8, 4'h7, 4'h6,
		4'h5, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0};
	// Chip enable, control bits, then osc, loop, buffer, regulator, external
	logic [9:0] modes [6] = '{10'h21e, 10'h242, 10'h280, 10'h0c2, 10'h30f,
		10'h2de};
	sspc_host i_sspc_host (.clk(clk), .sck(sck), .sd(sd), .ld(ld));
	sspc_ctrl i_sspc_ctrl (.CORE_CLK(clk), .RST_N(rst_n), .SER_CLK(sck),
		.SER_DATA(sd), .LOAD_STROBE(ld), .CHIP_ENABLE(ce), .REG_INDEX(idx),
		.REG_VALUE(rv), .WRITE_PULSE(wp), .WRITE_ADDR(wa), .CAL_START(cal),
		.FASTLOCK_START(fl), .OSC_ENABLE(en[4]), .LOOP_ENABLE(en[3]),
		.BUFFER_ENABLE(en[2]), .REGULATOR_ENABLE(en[1]),
		.FEEDBACK_EXTERNAL(en[0]), .DETECTOR_POLARITY(pol));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		if (cal === 1'b1) cal_n++;
		if (fl === 1'b1) fl_n++;
	end
	task automatic check(input string what, input logic [27:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [3:0] a, input logic [27:0] d);
		i_sspc_host.load({4'hf, d, a}, 36);
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [27:0] exp);
		idx <= a;
		repeat (2) @(posedge clk);
		check("value", rv, exp);
	endtask : rd
	task automatic t_init();
		wr(4'h5, 28'h000_0001);
		foreach (order[i]) wr(order[i], {order[i], 24'h00_0a50});
		foreach (order[i]) rd(order[i], {order[i], 24'h00_0a50});
		check("addr", 28'(wa), 28'h000_0000);
		check("enables", 28'(en), 28'h000_0000);
	endtask : t_init
	task automatic t_hold();
		i_sspc_host.load(36'h0_0000_0000, 0);
		rd(4'h0, 28'h000_0a50);
	endtask : t_hold
	task automatic t_modes();
		foreach (modes[i]) begin
			ce <= modes[i][9];
			wr(4'h5, {24'h00_0000, modes[i][8:5]});
			check("enables", 28'(en), 28'(modes[i][4:0]));
		end
		wr(4'h3, 28'h000_0000);
		wr(4'h1, 28'h000_0001);
		wr(4'h0, 28'h000_0001);
		check("polarity", 28'(pol), 28'h000_0001);
	endtask : t_modes
	task automatic t_swreset();
		wr(4'h5, 28'h000_0001);
		rd(4'h4, 28'h000_0000);
		rd(4'h5, 28'h000_0000);
		wr(4'h0, 28'h000_0000);
		check("pulses", 28'({cal_n[3:0], fl_n[3:0]}), 28'h000_0033);
	endtask : t_swreset
	task automatic tally_and_finish();
		$display("Checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : tally_and_finish
	initial begin
		#1_000_000;
		err_total++;
		tally_and_finish();
	end
	initial begin
		rst_n = 1'b0;
		ce = 1'b0;
		idx = 4'h0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		t_init();
		// Settle wait, shortened: the block keeps no timer of its own
		repeat (500) @(posedge clk);
		t_hold();
		t_modes();
		t_swreset();
		tally_and_finish();
	end
endmodule : sspc_ctrl_tb
`default_nettype wire

// File: testbench/sspc_host.sv
// Host model: serial clock, data and load strobe.
// Assumes the bench clock; serial clock idles low.
`default_nettype none
module sspc_host (
	input wire logic clk,
	output logic sck,
	output logic sd,
	output logic ld
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		sck = 1'b0;
		sd = 1'b0;
		ld = 1'b1;
	end
	// One 320 ns serial clock period
	task automatic bit_out(input logic b);
		@(posedge clk) sd <= b;
		repeat (4) @(posedge clk) sck <= 1'b1;
		repeat (3) @(posedge clk) sck <= 1'b0;
	endtask : bit_out
	// Idle data inverts and one stray clock follows the latch
	task automatic load(input logic [35:0] w, input int n);
		@(posedge clk) ld <= 1'b0;
		for (int i = n - 1; i >= 0; i--) bit_out(w[i]);
		repeat (6) @(posedge clk);
		ld <= 1'b1;
		bit_out(~sd);
		repeat (8) @(posedge clk);
	endtask : load
endmodule : sspc_host
`default_nettype wire
